// *** fbc_defs.vh ***
/*
 flash bus controller constants: register offsets, field positions, timings in ns and cycles.
 assumes a 40 MHz controller clock (25 ns period).
*/
`ifndef FBC_DEFS_VH
`define FBC_DEFS_VH
// ==========================================
// register offsets (byte addresses)
`define FBC_CTRL_OFF 4'h0
`define FBC_ADDR_OFF 4'h4
`define FBC_DATA_OFF 4'h8
`define FBC_STAT_OFF 4'hC
// ==========================================
// control fields
`define FBC_CTRL_GO 0
`define FBC_CTRL_OP_LO 1
`define FBC_CTRL_OP_HI 3
`define FBC_CTRL_PROT 4
`define FBC_CTRL_UNPROT 5
`define FBC_CTRL_UNLOCK 6
// commands
`define FBC_OP_READ 3'h0
`define FBC_OP_WRITE 3'h1
`define FBC_OP_RESET 3'h2
`define FBC_OP_STANDBY 3'h3
// status fields
`define FBC_STAT_BUSY 0
`define FBC_STAT_RDY 1
`define FBC_STAT_DONE 2
// ==========================================
// timing in ns and derived cycles
`define FBC_CLK_NS 25
`define FBC_T_RP_NS 500
`define FBC_T_RH_NS 50
`define FBC_T_RPD_NS 20000
`define FBC_T_WC_NS 70
`define FBC_T_WP_NS 35
`define FBC_T_WPH_NS 30
`define FBC_T_ACC_NS 70
`define FBC_T_RSP_NS 4000
`define FBC_T_READY_NS 20000
`define FBC_CYC(ns) (((ns) + `FBC_CLK_NS - 1) / `FBC_CLK_NS)
`endif

// *** fbc_ctrl.v ***
/*
 flash bus controller: drives chip select, output enable, write strobe, address, data
 and reset pins of an asynchronous parallel flash; ordered over axi4-lite.
 assumes ready_busy_n and dq inputs are asynchronous and get synchronised here.
*/
`include "fbc_defs.vh"
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - reset pulse held low at least 500 ns.
// - wait at least 50 ns after reset release before a read.
// - hold reset low at least 20 us for standby.
// - write cycles spaced by at least the write cycle time.
// - no extra delay from output enable high to write strobe low.
// - write strobe stays high at least 30 ns between strobes.
// - next operation may start as soon as ready shows.
// - status reads delimited by output enable or chip select.
// - elevated unlock voltage held 4 us before the first write.
// - protect uses line six low, line one high, line zero low.
// - unprotect uses line six high, line one high, line zero low.
module fbc_ctrl #(
  parameter AW = 21,
  parameter T_WC_NS = `FBC_T_WC_NS,
  parameter RPD_CYC = `FBC_CYC(`FBC_T_RPD_NS),
  parameter READY_CYC = `FBC_CYC(`FBC_T_READY_NS)
)(
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg chip_select_n,
  output reg output_enable_n,
  output reg write_strobe_n,
  output reg hw_reset_n,
  output reg elevated_unlock_voltage,
  output reg [AW-1:0] flash_addr,
  output reg [7:0] dq_out,
  output reg dq_oe,
  input wire [7:0] dq_in,
  input wire ready_busy_n
);
// ==========================================
// timing counts
localparam [23:0] WC_CYC = (T_WC_NS + `FBC_CLK_NS - 1) / `FBC_CLK_NS;
localparam [23:0] WP_CYC = `FBC_CYC(`FBC_T_WP_NS);
localparam [23:0] WPH_CYC = `FBC_CYC(`FBC_T_WPH_NS);
localparam [23:0] RP_CYC = `FBC_CYC(`FBC_T_RP_NS);
localparam [23:0] RH_CYC = `FBC_CYC(`FBC_T_RH_NS);
localparam [23:0] ACC_CYC = `FBC_CYC(`FBC_T_ACC_NS) + 24'h000001;
localparam [23:0] RSP_CYC = `FBC_CYC(`FBC_T_RSP_NS);
localparam [23:0] RPD_C = RPD_CYC;
localparam [23:0] READY_C = READY_CYC;
// states
localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_RD = 3'h1;
localparam [2:0] S_WLOW = 3'h2;
localparam [2:0] S_WHIGH = 3'h3;
localparam [2:0] S_RST = 3'h4;
localparam [2:0] S_RREC = 3'h5;
localparam [2:0] S_UNLK = 3'h6;
// ==========================================
// synchronisers
reg [1:0] rb_sync_reg;
reg [7:0] dq_s1_reg;
reg [7:0] dq_s2_reg;
always @(posedge aclk)
begin
  rb_sync_reg <= {rb_sync_reg[0], ready_busy_n};
  dq_s1_reg <= dq_in;
  dq_s2_reg <= dq_s1_reg;
end
wire dev_ready = rb_sync_reg[1];
// ==========================================
// register file and bus slave
reg [6:0] ctrl_reg;
reg [AW-1:0] addr_reg;
reg [7:0] wdata_reg;
reg [7:0] rdata_reg;
reg done_reg;
reg [2:0] state_reg;
reg [23:0] cnt_reg;
reg aw_got_reg;
reg w_got_reg;
reg [3:0] aw_addr_reg;
reg [31:0] w_data_reg;
wire busy = (state_reg != S_IDLE);
assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
assign s_axi_wready = !w_got_reg && !s_axi_bvalid;
assign s_axi_arready = !s_axi_rvalid;
wire aw_now = aw_got_reg || s_axi_awvalid;
wire w_now = w_got_reg || s_axi_wvalid;
wire [3:0] wa = aw_got_reg ? aw_addr_reg : s_axi_awaddr;
wire [31:0] wd = w_got_reg ? w_data_reg : s_axi_wdata;
wire wr_fire = aw_now && w_now && !s_axi_bvalid;
wire go_pulse = wr_fire && (wa == `FBC_CTRL_OFF) && wd[`FBC_CTRL_GO] && !busy;
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    aw_got_reg <= 1'b0;
    w_got_reg <= 1'b0;
    aw_addr_reg <= 4'h0;
    w_data_reg <= 32'h00000000;
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= 2'h0;
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= 2'h0;
    s_axi_rdata <= 32'h00000000;
    ctrl_reg <= 7'h00;
    addr_reg <= {AW{1'b0}};
    wdata_reg <= 8'h00;
  end
  else
  begin
    if (s_axi_bvalid && s_axi_bready)
      s_axi_bvalid <= 1'b0;
    if (wr_fire)
    begin
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= 2'h0;
      case (wa)
        `FBC_CTRL_OFF: if (!busy && s_axi_wstrb[0]) ctrl_reg <= wd[6:0];
        `FBC_ADDR_OFF: if (!busy) addr_reg <= wd[AW-1:0];
        `FBC_DATA_OFF: if (!busy && s_axi_wstrb[0]) wdata_reg <= wd[7:0];
        `FBC_STAT_OFF: s_axi_bresp <= 2'h0;
        default: s_axi_bresp <= 2'h2;
      endcase
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
      end
    end
    if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      case (s_axi_araddr)
        `FBC_CTRL_OFF: s_axi_rdata <= {25'h0000000, ctrl_reg};
        `FBC_ADDR_OFF: s_axi_rdata <= {{(32-AW){1'b0}}, addr_reg};
        `FBC_DATA_OFF: s_axi_rdata <= {24'h000000, rdata_reg};
        `FBC_STAT_OFF: s_axi_rdata <= {29'h00000000, done_reg, dev_ready, busy};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= 2'h2;
        end
      endcase
    end
  end
end
// ==========================================
// pin sequencer
reg wr_seen_reg;
always @(posedge aclk)
begin
  if (!aresetn)
  begin
    state_reg <= S_IDLE;
    cnt_reg <= 24'h000000;
    done_reg <= 1'b0;
    rdata_reg <= 8'h00;
    wr_seen_reg <= 1'b0;
    chip_select_n <= 1'b1;
    output_enable_n <= 1'b1;
    write_strobe_n <= 1'b1;
    hw_reset_n <= 1'b1;
    elevated_unlock_voltage <= 1'b0;
    flash_addr <= {AW{1'b0}};
    dq_out <= 8'h00;
    dq_oe <= 1'b0;
  end
  else
  begin
    if (wr_fire && wa == `FBC_STAT_OFF && wd[`FBC_STAT_DONE])
      done_reg <= 1'b0;
    // shared down-counter; a state that reloads it overrides this step
    if (cnt_reg != 24'h000000)
      cnt_reg <= cnt_reg - 24'h000001;
    case (state_reg)
      S_IDLE:
      begin
        elevated_unlock_voltage <= ctrl_reg[`FBC_CTRL_UNLOCK];
        if (!ctrl_reg[`FBC_CTRL_UNLOCK])
          wr_seen_reg <= 1'b0;
        if (go_pulse)
        begin
          done_reg <= 1'b0;
          flash_addr <= addr_reg;
          if (wd[`FBC_CTRL_PROT] || wd[`FBC_CTRL_UNPROT])
          begin
            flash_addr[6] <= wd[`FBC_CTRL_UNPROT];
            flash_addr[1] <= 1'b1;
            flash_addr[0] <= 1'b0;
          end
          case (wd[`FBC_CTRL_OP_HI:`FBC_CTRL_OP_LO])
            `FBC_OP_READ:
            begin
              chip_select_n <= 1'b0;
              output_enable_n <= 1'b0;
              cnt_reg <= ACC_CYC;
              state_reg <= S_RD;
            end
            `FBC_OP_WRITE:
            begin
              dq_out <= wdata_reg;
              dq_oe <= 1'b1;
              chip_select_n <= 1'b0;
              if (wd[`FBC_CTRL_UNLOCK] && !wr_seen_reg)
              begin
                elevated_unlock_voltage <= 1'b1;
                cnt_reg <= RSP_CYC;
                state_reg <= S_UNLK;
              end
              else
              begin
                write_strobe_n <= 1'b0;
                cnt_reg <= WP_CYC;
                state_reg <= S_WLOW;
              end
            end
            `FBC_OP_RESET:
            begin
              hw_reset_n <= 1'b0;
              cnt_reg <= RP_CYC;
              state_reg <= S_RST;
            end
            default:
            begin
              hw_reset_n <= 1'b0;
              cnt_reg <= RPD_C;
              state_reg <= S_RST;
            end
          endcase
        end
      end
      S_RD:
      begin
        if (cnt_reg <= 24'h000001)
        begin
          rdata_reg <= dq_s2_reg;
          chip_select_n <= 1'b1;
          output_enable_n <= 1'b1;
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
      end
      S_UNLK:
      begin
        if (cnt_reg <= 24'h000001)
        begin
          wr_seen_reg <= 1'b1;
          write_strobe_n <= 1'b0;
          cnt_reg <= WP_CYC;
          state_reg <= S_WLOW;
        end
      end
      S_WLOW:
      begin
        if (cnt_reg <= 24'h000001)
        begin
          write_strobe_n <= 1'b1;
          cnt_reg <= (WC_CYC > WP_CYC + WPH_CYC) ? WC_CYC - WP_CYC : WPH_CYC;
          state_reg <= S_WHIGH;
        end
      end
      S_WHIGH:
      begin
        chip_select_n <= 1'b1;
        dq_oe <= 1'b0;
        if (cnt_reg <= 24'h000001)
        begin
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
      end
      S_RST:
      begin
        if (cnt_reg <= 24'h000001)
        begin
          hw_reset_n <= 1'b1;
          cnt_reg <= dev_ready ? RH_CYC : READY_C;
          state_reg <= S_RREC;
        end
      end
      S_RREC:
      begin
        if (cnt_reg <= 24'h000001 || (dev_ready && cnt_reg <= RH_CYC))
        begin
          done_reg <= 1'b1;
          state_reg <= S_IDLE;
        end
      end
      default:
        state_reg <= S_IDLE;
    endcase
  end
end
endmodule
`default_nettype wire

// *** fbc_ctrl_properties.sv ***
/*
 pin timing checker for the flash bus controller, bound to fbc_ctrl.
 assumes a 25 ns aclk and synchronous active-low aresetn.
*/
`timescale 1ns/10ps
`default_nettype none
module fbc_ctrl_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic hw_reset_n,
  input wire logic elevated_unlock_voltage,
  input wire logic dq_oe
);
  logic [15:0] low_reg, high_reg, gap_reg, unl_reg;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ======================================
  // cycle counters
  always_ff @(posedge aclk)
  begin
    low_reg <= (!aresetn || hw_reset_n) ? 16'h0000 : low_reg + 16'h0001;
    high_reg <= !aresetn ? 16'h00FF : !hw_reset_n ? 16'h0000
      : high_reg + {15'h0000, high_reg != 16'h00FF};
    gap_reg <= !aresetn ? 16'h00FF : $fell(write_strobe_n) ? 16'h0001
      : gap_reg + {15'h0000, gap_reg != 16'h00FF};
    unl_reg <= (!aresetn || !elevated_unlock_voltage) ? 16'h0000
      : unl_reg + {15'h0000, unl_reg != 16'h00FF};
  end
  // ======================================
  // properties
  property p_rst_pulse; $rose(hw_reset_n) |-> low_reg >= 16'h0014; endproperty
  property p_rd_after_rst; $fell(output_enable_n) |-> high_reg >= 16'h0002; endproperty
  property p_wr_cycle; $fell(write_strobe_n) |-> gap_reg >= 16'h0003; endproperty
  property p_wr_high; $rose(write_strobe_n) |=> write_strobe_n; endproperty
  property p_oe_we; !output_enable_n |-> write_strobe_n; endproperty
  property p_unlock;
    $fell(write_strobe_n) && elevated_unlock_voltage |-> unl_reg >= 16'h00A0;
  endproperty
  property p_dq_oe; dq_oe |-> output_enable_n && chip_select_n == 1'b0; endproperty
  property p_cs; !write_strobe_n || !output_enable_n |-> !chip_select_n; endproperty
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pulse too short");
  a_rd_after_rst: assert property (p_rd_after_rst)
    else $error("read too soon after reset release");
  a_wr_cycle: assert property (p_wr_cycle)
    else $error("write cycles too close");
  a_wr_high: assert property (p_wr_high)
    else $error("write strobe high time too short");
  a_oe_we: assert property (p_oe_we)
    else $error("output enable and write strobe both low");
  a_unlock: assert property (p_unlock)
    else $error("write too soon after unlock voltage");
  a_dq_oe: assert property (p_dq_oe)
    else $error("data driven outside a write access");
  a_cs: assert property (p_cs)
    else $error("strobe without chip select");
  c_write: cover property ($fell(write_strobe_n));
  c_reset: cover property ($rose(hw_reset_n));
  c_unlock: cover property (elevated_unlock_voltage && !write_strobe_n);
endmodule
bind fbc_ctrl fbc_ctrl_properties u_props (.aclk(aclk), .aresetn(aresetn),
  .chip_select_n(chip_select_n), .output_enable_n(output_enable_n),
  .write_strobe_n(write_strobe_n), .hw_reset_n(hw_reset_n),
  .elevated_unlock_voltage(elevated_unlock_voltage), .dq_oe(dq_oe));
`default_nettype wire

// *** fbc_flash_model.sv ***
/*
 behavioural flash device: 256-byte array, busy output, toggle status, reset abort.
 assumes any accepted write programs one byte; no clock of its own.
*/
`timescale 1ns/10ps
`default_nettype none
module fbc_flash_model #(
  parameter integer PROG_NS = 4000
)(
  input wire logic chip_select_n,
  input wire logic output_enable_n,
  input wire logic write_strobe_n,
  input wire logic hw_reset_n,
  input wire logic [20:0] flash_addr,
  input wire logic [7:0] dq_out,
  output wire logic [7:0] dq_in,
  output var logic ready_busy_n
);
  logic [7:0] mem [0:255];
  logic [7:0] last, drv;
  logic tog;
  wire rd_n = output_enable_n | chip_select_n;
  initial
  begin
    ready_busy_n = 1'b1;
    tog = 1'b0;
    last = 8'h00;
    foreach (mem[i]) mem[i] = 8'hFF;
  end
  // ======================================
  // program: busy 20 ns after the strobe, ready when done
  always @(posedge write_strobe_n)
  begin : prog_op
    if (!chip_select_n && hw_reset_n)
    begin
      mem[flash_addr[7:0]] = dq_out;
      #20 ready_busy_n = 1'b0;
      #(PROG_NS) ready_busy_n = 1'b1;
    end
  end
  // reset aborts a running program; idle reset leaves ready high
  always @(negedge hw_reset_n)
  begin
    if (!ready_busy_n)
    begin
      disable prog_op;
      #400 ready_busy_n = 1'b1;
    end
  end
  // ======================================
  // status toggles on each new access; released bus shows inverse
  always @(negedge rd_n) tog = ~tog;
  // no sector is ever erase-suspended here, so bit 2 of status stays low
  assign drv = ready_busy_n ? mem[flash_addr[7:0]] : {1'b0, tog, 6'h00};
  always @(drv or rd_n) if (!rd_n) last = drv;
  assign dq_in = rd_n ? ~last : drv;
endmodule
`default_nettype wire

// *** fbc_tb.sv ***
/*
 testbench for fbc_ctrl: axi4-lite master, flash model, row table then hand tests.
 assumes fbc_flash_model and the bound checker are compiled first.
*/
`include "fbc_defs.vh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic chip_select_n, output_enable_n, write_strobe_n, hw_reset_n, elevated_unlock_voltage;
  logic dq_oe, ready_busy_n;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, s;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [20:0] flash_addr, wr_addr;
  logic [7:0] dq_out, dq_in, t0, t1;
  logic [15:0] low_n = 16'h0000, low_max = 16'h0000;
  int n_fail = 0, checks_done = 0;
  logic [28:0] rows [4] = '{{21'h10, 8'h5A}, {21'h11, 8'hA5}, {21'hFF, 8'h00}, {21'h0, 8'h81}};
  fbc_ctrl #(.READY_CYC(20)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_select_n, .output_enable_n,
    .write_strobe_n, .hw_reset_n, .elevated_unlock_voltage, .flash_addr, .dq_out, .dq_oe,
    .dq_in, .ready_busy_n);
  fbc_flash_model u_flash (.chip_select_n, .output_enable_n, .write_strobe_n, .hw_reset_n,
    .flash_addr, .dq_out, .dq_in, .ready_busy_n);
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // ======================================
  // pin monitors
  always @(posedge aclk)
  begin
    low_n <= hw_reset_n ? 16'h0000 : low_n + 16'h0001;
    if (hw_reset_n && low_n != 16'h0000) low_max <= low_n;
    if (!write_strobe_n) wr_addr <= flash_addr;
  end
  // ======================================
  // bus tasks
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw_ok = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w_ok = 1'b1;
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    `CHK(s_axi_bresp, 2'h0)
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    `CHK(s_axi_rresp, 2'h0)
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic op(input logic [31:0] ctrl);
    axi_wr(4'h0, ctrl);
    s = 32'h0;
    while (!s[2]) axi_rd(4'hC, s);
    axi_wr(4'hC, 32'h4);
  endtask
  task automatic prog(input logic [20:0] a, input logic [7:0] d, input logic [31:0] ctrl);
    axi_wr(4'h4, {11'h000, a});
    axi_wr(4'h8, {24'h000000, d});
    op(ctrl);
  endtask
  task automatic wait_rdy;
    s = 32'h0;
    while (!s[1]) axi_rd(4'hC, s);
  endtask
  task automatic rd_byte(input logic [20:0] a, output logic [7:0] d);
    axi_wr(4'h4, {11'h000, a});
    op(32'h1);
    axi_rd(4'h8, s);
    d = s[7:0];
  endtask
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run;
  end
  // ======================================
  // main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i])
    begin
      prog(rows[i][28:8], rows[i][7:0], 32'h3);
      wait_rdy;
      rd_byte(rows[i][28:8], t0);
      `CHK(t0, rows[i][7:0])
    end
    prog(21'h20, 8'h3C, 32'h3);
    rd_byte(21'h1ABCDE, t0);
    rd_byte(21'h000001, t1);
    `CHK(t0[6] ^ t1[6], 1'b1)
    axi_rd(4'hC, s);
    `CHK(s[1], 1'b0)
    op(32'h5);
    axi_rd(4'hC, s);
    `CHK(s[1], 1'b1)
    `CHK(low_max >= 16'h0014, 1'b1)
    rd_byte(21'h10, t0);
    `CHK(t0, 8'h5A)
    op(32'h7);
    `CHK(low_max >= `FBC_CYC(`FBC_T_RPD_NS), 1'b1)
    axi_rd(4'hC, s);
    `CHK(s[1], 1'b1)
    prog(21'h1FFFFF, 8'h00, 32'h13);
    wait_rdy;
    `CHK({wr_addr[6], wr_addr[1:0]}, 3'h2)
    prog(21'h0, 8'h00, 32'h23);
    wait_rdy;
    `CHK({wr_addr[6], wr_addr[1:0]}, 3'h6)
    prog(21'h30, 8'h11, 32'h43);
    wait_rdy;
    `CHK(wr_addr, 21'h000030)
    complete_run;
  end
endmodule
`default_nettype wire
